// file: design/uef_top.v
// Purpose: endpoint interrupt flags, fifo data port, byte count and frame number low
// Assumes: cpu register port on the cpu clock; usb engine events same clock
// Notes:   register reads are registered; read data valid one cycle after sfr_rd
`timescale 1ns/1ps
`include "uef_map.vh"

module uef_top #(
  parameter DEPTH = `UEF_FIFO_DEPTH,
  parameter AW    = 6
) (
  // clock, reset, enable
  input  wire                      clk,
  input  wire                      nrst,
  input  wire                      ce,
  // cpu register port
  input  wire [7:0]                sfr_addr,
  input  wire                      sfr_wr,
  input  wire                      sfr_rd,
  input  wire [7:0]                sfr_wdata,
  output reg  [7:0]                sfr_rdata,
  // settings from neighbouring registers
  input  wire [1:0]                endpoint_select,
  input  wire [2:0]                endpoint_irq_enable,
  // endpoint status sources, 5 bits per endpoint
  input  wire [3*`UEF_SRC_BITS-1:0] endpoint_status_src,
  // usb engine side: received bytes and start of frame
  input  wire                      rx_push,
  input  wire [1:0]                rx_ep,
  input  wire [7:0]                rx_byte,
  input  wire                      sof_valid,
  input  wire                      sof_crc_ok,
  input  wire [10:0]               sof_frame,
  // engine pop request, and outputs to engine and cpu
  input  wire                      tx_pop,
  input  wire [1:0]                tx_ep,
  output reg  [7:0]                tx_byte,
  output reg  [2:0]                endpoint_interrupt_flags,
  output reg                       usb_irq,
  output reg  [10:0]               frame_number
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire data_wr = ce && sfr_wr && hit(sfr_addr, `UEF_OFS_FIFO_DATA);
  wire data_rd = ce && sfr_rd && hit(sfr_addr, `UEF_OFS_FIFO_DATA);

  // ----------------------------------------------------------------
  // per-endpoint fifos
  // ----------------------------------------------------------------
  wire [7:0]                 ep_rdata [0:2];
  wire [`UEF_CNT_BITS-1:0]   ep_cnt   [0:2];
  wire [2:0]                 src_any;

  genvar g;
  generate
    for (g = 0; g < `UEF_NUM_EP; g = g + 1) begin : g_ep
      wire sel_g = (endpoint_select == g);
      // cpu writes push toward host, engine receive pushes too
      wire push_g = (data_wr && sel_g) || (ce && rx_push && (rx_ep == g));
      wire pop_g  = (data_rd && sel_g) || (ce && tx_pop && (tx_ep == g));
      uef_ep_fifo #(
        .DEPTH (DEPTH),
        .AW    (AW),
        .CW    (`UEF_CNT_BITS)
      ) u_fifo (
        .clk   (clk),
        .nrst  (nrst),
        .ce    (ce),
        .push  (push_g),
        .wdata ((data_wr && sel_g) ? sfr_wdata : rx_byte),
        .pop   (pop_g),
        .rdata (ep_rdata[g]),
        .count (ep_cnt[g])
      );
      // any of five status sources
      assign src_any[g] = |endpoint_status_src[g*`UEF_SRC_BITS +: `UEF_SRC_BITS];
    end
  endgenerate

  // ----------------------------------------------------------------
  // selected endpoint views
  // ----------------------------------------------------------------
  wire [1:0] sel_ix = (endpoint_select == 2'd3) ? 2'd0 : endpoint_select;
  wire [1:0] tx_ix  = (tx_ep == 2'd3) ? 2'd0 : tx_ep;
  wire [`UEF_CNT_BITS-1:0] sel_cnt = ep_cnt[sel_ix];

  // ----------------------------------------------------------------
  // flags follow sources; cleared only when all sources clear
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      endpoint_interrupt_flags <= 3'b000;
      usb_irq                  <= 1'b0;
    end else if (ce) begin
      endpoint_interrupt_flags <= src_any;
      usb_irq <= |(src_any & endpoint_irq_enable);
    end
  end

  // ----------------------------------------------------------------
  // frame number from good start of frame
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_number <= `UEF_RST_FRAME;
    end else if (ce && sof_valid && sof_crc_ok) begin
      frame_number <= sof_frame;
    end
  end

  // ----------------------------------------------------------------
  // register read mux and engine byte
  // ----------------------------------------------------------------
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sfr_rdata <= 8'h00;
      tx_byte   <= 8'h00;
    end else if (ce) begin
      if (tx_pop) begin
        tx_byte <= ep_rdata[tx_ix];
      end
      if (sfr_rd) begin
        case (sfr_addr)
          `UEF_OFS_FRAME_LOW:  sfr_rdata <= frame_number[7:0];
          `UEF_OFS_FIFO_DATA:  sfr_rdata <= ep_rdata[sel_ix];
          `UEF_OFS_BYTE_COUNT: sfr_rdata <= {1'b0, sel_cnt};
          `UEF_OFS_IRQ_FLAGS:  sfr_rdata <= {5'h00, endpoint_interrupt_flags};
          default:             sfr_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule

// file: design/uef_map.vh
// Purpose: offsets, field positions, reset values for the endpoint flag/fifo/frame block
// Assumes: special-function register space with 8-bit addresses
// Notes:   included by bare name
`ifndef UEF_MAP_VH
`define UEF_MAP_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define UEF_OFS_FRAME_LOW   8'hba
`define UEF_OFS_FIFO_DATA   8'hcf
`define UEF_OFS_BYTE_COUNT  8'he2
`define UEF_OFS_IRQ_FLAGS   8'hf8

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define UEF_NUM_EP          3
`define UEF_SRC_BITS        5
`define UEF_CNT_BITS        7
`define UEF_RST_IRQ_FLAGS   8'h00
`define UEF_RST_BYTE_COUNT  7'h00
`define UEF_RST_FRAME       11'h000
`define UEF_FIFO_DEPTH      64

`endif

// file: design/uef_ep_fifo.v
// Purpose: one endpoint byte fifo with occupancy count
// Assumes: single clock; a push when full or a pop when empty is dropped by the full/empty guards
// Notes:   contents are undefined after reset
`timescale 1ns/1ps

module uef_ep_fifo #(
  parameter DEPTH = 64,
  parameter AW    = 6,
  parameter CW    = 7
) (
  // clock and reset
  input  wire          clk,
  input  wire          nrst,
  input  wire          ce,
  // byte ports
  input  wire          push,
  input  wire [7:0]    wdata,
  input  wire          pop,
  output wire [7:0]    rdata,
  output wire [CW-1:0] count
);

  // full level sized to the count, so compares need no part-select of a parameter
  localparam [CW-1:0] FULL = DEPTH;

  reg [7:0]    mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [CW-1:0] cnt_r;

  assign rdata = mem_r[rp_r];
  assign count = cnt_r;

  // storage, no reset on data
  always @(posedge clk) begin
    if (ce && push && (cnt_r != FULL)) begin
      mem_r[wp_r] <= wdata;
    end
  end

  // pointers and count, full/empty guarded
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {CW{1'b0}};
    end else if (ce) begin
      if (push && (cnt_r != FULL)) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop && (cnt_r != {CW{1'b0}})) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{(CW-1){1'b0}}, push && (cnt_r != FULL)}
                     - {{(CW-1){1'b0}}, pop && (cnt_r != {CW{1'b0}})};
    end
  end

endmodule

// file: verification/uef_top_chk.sv
// Purpose: port checker for uef_top
// Assumes: one clock, nrst async low
// Notes: bound after the module
`timescale 1ns/1ps
module uef_chk (
  // watched ports
  input wire        clk,
  input wire        nrst,
  input wire        ce,
  input wire        sfr_rd,
  input wire [7:0]  sfr_addr,
  input wire [7:0]  sfr_rdata,
  input wire [2:0]  endpoint_irq_enable,
  input wire [14:0] endpoint_status_src,
  input wire        sof_valid,
  input wire        sof_crc_ok,
  input wire [10:0] sof_frame,
  input wire [2:0]  endpoint_interrupt_flags,
  input wire        usb_irq,
  input wire [10:0] frame_number
);
  // any active source per endpoint
  wire [2:0] src = {|endpoint_status_src[14:10], |endpoint_status_src[9:5],
                    |endpoint_status_src[4:0]};
  wire       rd = ce && sfr_rd;
  wire [7:0] fl = frame_number[7:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_flag_track: assert property (ce |=> endpoint_interrupt_flags == $past(src)) else $error("flag");
  a_irq_gate: assert property (ce |=> usb_irq == |($past(src) & $past(endpoint_irq_enable))) else $error("irq");
  a_flag_read: assert property (rd && sfr_addr == 8'hf8 |=> sfr_rdata[2:0] == $past(endpoint_interrupt_flags)) else $error("flag rd");
  a_flag_rsvd: assert property (rd && sfr_addr == 8'hf8 |=> sfr_rdata[7:3] == 5'h00) else $error("flag hi");
  a_count_rsvd: assert property (rd && sfr_addr == 8'he2 |=> !sfr_rdata[7]) else $error("count hi");
  a_frame_read: assert property (rd && sfr_addr == 8'hba |=> sfr_rdata == $past(fl)) else $error("frame rd");
  a_frame_load: assert property (ce && sof_valid && sof_crc_ok |=> frame_number == $past(sof_frame)) else $error("sof");
  a_frame_keep: assert property (ce && sof_valid && !sof_crc_ok |=> $stable(frame_number)) else $error("bad sof");
  c_irq: cover property (usb_irq);
  c_bad_sof: cover property (sof_valid && !sof_crc_ok);
  c_fifo_rd: cover property (rd && sfr_addr == 8'hcf);
endmodule
bind uef_top uef_chk u_chk (.*);

// file: verification/uef_host_mdl.sv
// Purpose: usb host stand-in feeding bytes and sof
// Assumes: drives on the falling edge
// Notes: idle data shows the inverse of the last value
`timescale 1ns/1ps
module uef_host_mdl (
  // engine side
  input  wire        clk,
  output reg         rx_push = 1'b0,
  output reg  [1:0]  rx_ep = 2'h0,
  output reg  [7:0]  rx_byte = 8'h00,
  output reg         sof_valid = 1'b0,
  output reg         sof_crc_ok = 1'b0,
  output reg  [10:0] sof_frame = 11'h000
);
  // one received byte for endpoint e
  task send_byte(input [1:0] e, input [7:0] b);
    begin
      @(negedge clk) {rx_push, rx_ep, rx_byte} = {1'b1, e, b};
      @(negedge clk) {rx_push, rx_byte} = {1'b0, ~b};
    end
  endtask
  // one sof, ok low for a corrupted number
  task send_sof(input [10:0] f, input ok);
    begin
      @(negedge clk) {sof_valid, sof_crc_ok, sof_frame} = {1'b1, ok, f};
      @(negedge clk) {sof_valid, sof_frame} = {1'b0, ~f};
    end
  endtask
endmodule

// file: verification/uef_top_tb.sv
// Purpose: self-checking bench for uef_top
// Assumes: inputs change on the falling edge
// Notes: tx side idle except one engine pop from endpoint 1
`timescale 1ns/1ps
module uef_top_tb;
  reg clk = 1'b0, nrst = 1'b0, ce = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, tx_pop = 1'b0;
  reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v;
  reg [1:0] endpoint_select = 2'h0, tx_ep = 2'h0;
  reg [2:0] endpoint_irq_enable = 3'h0;
  reg [14:0] endpoint_status_src = 15'h0000;
  wire [7:0] sfr_rdata, tx_byte, rx_byte;
  wire [2:0] endpoint_interrupt_flags;
  wire usb_irq, rx_push, sof_valid, sof_crc_ok;
  wire [1:0] rx_ep;
  wire [10:0] sof_frame, frame_number;
  integer fail_count = 0, n_compared = 0, i, j;
  uef_top dut (.*);
  uef_host_mdl host (.*);
  always #4 clk = ~clk;
  // compare and count
  task chk(input [10:0] seen, input [10:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  // register accesses, strobe for one cycle
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk) {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
      @(negedge clk) sfr_wr = 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(negedge clk) {sfr_rd, sfr_addr} = {1'b1, a};
      @(negedge clk) sfr_rd = 1'b0;
      v = sfr_rdata;
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    // reset values, then an unmapped place
    for (i = 0; i < 4; i = i + 1) begin
      rd(i == 0 ? 8'hf8 : i == 1 ? 8'he2 : i == 2 ? 8'hba : 8'h10);
      chk(v, 8'h00);
    end
    // fill three fifos, drain in reverse endpoint order
    for (i = 0; i < 3; i = i + 1) begin
      endpoint_select = i[1:0];
      for (j = 0; j < 3; j = j + 1) wr(8'hcf, 8'h10 * i + j);
    end
    for (i = 2; i >= 0; i = i - 1) begin
      endpoint_select = i[1:0];
      for (j = 0; j < 4; j = j + 1) begin
        rd(8'he2);
        chk(v, 3 - j);
        if (j < 3) rd(8'hcf);
        if (j < 3) chk(v, 8'h10 * i + j);
      end
    end
    // bytes received from the host
    host.send_byte(2'h1, 8'ha5);
    host.send_byte(2'h1, 8'h5a);
    endpoint_select = 2'h1;
    rd(8'he2);
    chk(v, 8'h02);
    rd(8'hcf);
    chk(v, 8'ha5);
    // every source, enables alternately on and off
    for (i = 0; i < 15; i = i + 1) begin
      endpoint_status_src = 15'h0001 << i;
      endpoint_irq_enable = {3{i[0]}};
      rd(8'hf8);
      chk(v, 8'h01 << (i / 5));
      chk(usb_irq, i[0]);
    end
    endpoint_status_src = 15'h0000;
    rd(8'hf8);
    chk(v, 8'h00);
    // good then corrupted start of frame
    host.send_sof(11'h5a3, 1'b1);
    host.send_sof(11'h1ff, 1'b0);
    rd(8'hba);
    chk(v, 8'ha3);
    chk(frame_number, 11'h5a3);
    // engine pops the byte left in endpoint 1
    @(negedge clk) {tx_pop, tx_ep} = {1'b1, 2'h1};
    @(negedge clk) tx_pop = 1'b0;
    chk(tx_byte, 8'h5a);
    rd(8'he2);
    chk(v, 8'h00);
    // clock enable low: a received byte must not land
    ce = 1'b0;
    host.send_byte(2'h2, 8'h33);
    ce = 1'b1;
    endpoint_select = 2'h2;
    rd(8'he2);
    chk(v, 8'h00);
    complete_run;
  end
  // watchdog
  initial begin
    #20000;
    fail_count = fail_count + 1;
    complete_run;
  end
endmodule
